// file: hw/wts_map.svh
/*
  Register offsets, bit positions, reset values and timing counts of the
  wavetable voice engine.
  Assumes it is included by bare name from files that need the map.
*/
`ifndef WTS_MAP_SVH
`define WTS_MAP_SVH

`define WTS_OFF_CONV_HI    8'h1D
`define WTS_OFF_CONV_LO    8'h1E
`define WTS_OFF_CONV_CTL   8'h1F
`define WTS_OFF_VOICE_SEL  8'h20
`define WTS_OFF_PITCH_HI   8'h21
`define WTS_OFF_PITCH_LO   8'h22
`define WTS_OFF_BASE_HI    8'h23
`define WTS_OFF_BASE_LO    8'h24
`define WTS_OFF_FMT_LOOP   8'h25
`define WTS_OFF_LOOP_LO    8'h26
`define WTS_OFF_ENV_VOL    8'h27
`define WTS_OFF_VOL_LO     8'h2A

`define WTS_BIT_CONV_EN    1
`define WTS_BIT_SRC_SEL    0
`define WTS_BIT_VOL_ONLY   7
`define WTS_BIT_PITCH_ONLY 6
`define WTS_BIT_WIDE       7
`define WTS_BIT_FADE_DIR   7

`define WTS_RST_CTL        1'b0
`define WTS_RST_VSEL       8'h00
`define WTS_END_CODE       8'h80
`define WTS_ALIGN_ZERO     5'h00
`define WTS_LOOP_SEXT      6'h3F
`define WTS_SILENT_HI      7'h7F
`define WTS_LAST_VOICE     3'h7
`define WTS_ODD_NIB_OFF    16'h0002
`define WTS_PAIR_BYTES     16'h0003

`define WTS_CLK_HZ         100000000
`define WTS_RATE_HZ        25000
`define WTS_FRAME_CYC      (`WTS_CLK_HZ / `WTS_RATE_HZ)

`endif

// file: hw/wts_pkg.sv
/*
  Types of the wavetable voice engine: port carriers, voice settings,
  voice play state, sequencer states and the whole engine state.
  Assumes wts_map.svh is available for the numbers.
*/
package wts_pkg;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } wts_reg_req_t;

  typedef struct packed {
    logic        rd;
    logic [15:0] addr;
  } wts_rom_req_t;

  typedef struct packed {
    logic [11:0] step;
    logic [3:0]  shift;
    logic [11:0] base;
    logic        wide;
    logic [9:0]  loop_off;
    logic        fade_dir;
    logic [1:0]  span;
    logic [9:0]  atten;
  } wts_voice_cfg_t;

  typedef struct packed {
    logic        active;
    logic        looped;
    logic [15:0] idx;
    logic [16:0] frac;
  } wts_voice_play_t;

  typedef enum logic [7:0] {
    WTS_S_IDLE    = 8'h01,
    WTS_S_REQ     = 8'h02,
    WTS_S_WAIT_HI = 8'h04,
    WTS_S_GET_HI  = 8'h08,
    WTS_S_WAIT_LO = 8'h10,
    WTS_S_GET_LO  = 8'h20,
    WTS_S_MIX     = 8'h40,
    WTS_S_NEXT    = 8'h80
  } wts_seq_t;

  typedef struct packed {
    logic [7:0]             conv_hi;
    logic [7:0]             conv_lo;
    logic                   conv_en;
    logic                   src_sel;
    logic [7:0]             vsel;
    wts_voice_cfg_t         stage;
    wts_voice_cfg_t [7:0]   cfg;
    wts_voice_play_t [7:0]  play;
    wts_seq_t               seq;
    logic [11:0]            cyc;
    logic [2:0]             voice;
    logic                   last_done;
    logic [7:0]             hi_byte;
    logic [3:0]             lo_nib;
    logic [15:0]            acc;
    wts_rom_req_t           rom;
    logic [7:0]             rdata;
    logic [15:0]            conv_out;
  } wts_state_t;

endpackage : wts_pkg

// file: hw/wts_mix_add.sv
/*
  Scales one 12-bit signed sample by its attenuation and adds it to the
  running 16-bit mix with saturation.
  Assumes a purely combinational use inside the voice engine.
*/
`timescale 1ns/1ps
module wts_mix_add
(
  input  wire logic [11:0] sample,
  input  wire logic [9:0]  atten,
  input  wire logic [15:0] acc,
  output logic      [15:0] sum
);
  import wts_pkg::*;

  logic signed [22:0] prod;
  logic signed [16:0] wide_sum;
  logic        [9:0]  gain;

  always_comb
  begin
    // zero attenuation is full gain, all ones is silence
    gain     = ~atten;
    prod     = $signed(sample) * $signed({1'b0, gain});
    wide_sum = $signed({acc[15], acc}) + $signed({prod[21], prod[21:6]});
    // clip instead of wrap so loud chords do not flip sign
    if (wide_sum[16] != wide_sum[15])
    begin
      sum = wide_sum[16] ? 16'h8000 : 16'h7FFF;
    end
    else
    begin
      sum = wide_sum[15:0];
    end
  end

endmodule : wts_mix_add

// file: hw/wts_top.sv
/*
  Eight-voice wavetable engine with its byte register port and the
  converter word output.
  Assumes the core's register port is synchronous to core_clk and that
  the wave ROM returns the byte one cycle after rom_req.rd is seen.
*/
// How it works
// - converter word kept in two bytes
// - converter output on only while enabled
// - source select picks synthesizer or core
// - voice-select write picks voice and starts
// - update mode bits limit what gets applied
// - position steps by pitch over shifted scale
// - first sample address is base times 32
// - width bit picks 8-bit or packed 12-bit
// - play once then loop until silent
// - repeat point is end plus loop offset
// - 10-bit attenuation, zero is loudest
// - fade direction steps bits down or up
// - span field picks how many bits fade
// - 80H byte marks end of sequence
// - unused locations read zero, ignore writes
`timescale 1ns/1ps
`include "wts_map.svh"
module wts_top
(
  input  wire logic                  core_clk,
  input  wire logic                  rst,
  input  wire wts_pkg::wts_reg_req_t reg_req,
  output logic                [7:0]  reg_rdata,
  output wts_pkg::wts_rom_req_t      rom_req,
  input  wire logic           [7:0]  rom_data,
  output logic                       conv_on,
  output logic                [15:0] conv_word
);
  import wts_pkg::*;

  localparam logic [11:0] FRAME_LAST = 12'(`WTS_FRAME_CYC - 1);

  wts_state_t      core_ff;
  wts_state_t      nxt_core;
  wts_voice_cfg_t  cur;
  wts_voice_play_t pv;
  logic [15:0]     mix_sum;

  // sample address; also used for the nibble byte of packed samples
  function automatic logic [15:0] samp_addr
  (
    input logic [11:0] base,
    input logic [15:0] idx,
    input logic        wide,
    input logic        nib
  );
    logic [15:0] pair3;
    logic [15:0] off;
    pair3 = {1'b0, idx[15:1]} * `WTS_PAIR_BYTES;
    if (!wide)
    begin
      off = idx;
    end
    else if (nib)
    begin
      off = pair3 + `WTS_ODD_NIB_OFF;
    end
    else
    begin
      off = pair3 + {15'h0000, idx[0]};
    end
    // only eleven base bits fit above the five zero bits
    return {base[10:0], `WTS_ALIGN_ZERO} + off;
  endfunction : samp_addr

  // one envelope step on the selected low attenuation bits
  function automatic logic [9:0] fade_step
  (
    input logic [9:0] att,
    input logic [1:0] span,
    input logic       dir
  );
    logic [2:0] mask;
    logic [2:0] field;
    logic [2:0] nf;
    mask = 3'h0;
    case (span)
      2'b00:   mask = 3'h7;
      2'b01:   mask = 3'h3;
      2'b10:   mask = 3'h1;
      default: mask = 3'h0;
    endcase
    field = att[2:0] & mask;
    nf    = field;
    if (dir && field != 3'h0)
    begin
      nf = field - 3'h1;
    end
    else if (!dir && field != mask)
    begin
      nf = field + 3'h1;
    end
    return {att[9:3], (att[2:0] & ~mask) | nf};
  endfunction : fade_step

  assign cur = core_ff.cfg[core_ff.voice];
  assign pv  = core_ff.play[core_ff.voice];

  wts_mix_add u_mix
  (
    .sample (
      {core_ff.hi_byte, core_ff.lo_nib}),
    .atten  (cur.atten),
    .acc    (core_ff.acc),
    .sum    (mix_sum)
  );

  always_comb
  begin
    logic [32:0] pos;
    logic [26:0] inc;
    logic [9:0]  att_new;
    logic [2:0]  v;
    nxt_core          = core_ff;
    pos               = {pv.idx, pv.frac};
    inc               = {15'h0000, cur.step} << cur.shift;
    att_new           = fade_step(cur.atten, cur.span, cur.fade_dir);
    v                 = reg_req.wdata[2:0];
    nxt_core.rom.rd   = 1'b0;
    nxt_core.last_done = 1'b0;

    // frame counter paces the whole voice sweep
    if (core_ff.cyc == FRAME_LAST)
    begin
      nxt_core.cyc = 12'h000;
    end
    else
    begin
      nxt_core.cyc = core_ff.cyc + 12'h001;
    end

    case (core_ff.seq)
      WTS_S_IDLE:
      begin
        if (core_ff.cyc == 12'h000)
        begin
          nxt_core.voice = 3'h0;
          nxt_core.acc   = 16'h0000;
          nxt_core.seq   = WTS_S_REQ;
        end
      end
      WTS_S_REQ:
      begin
        if (pv.active)
        begin
          nxt_core.rom.addr = samp_addr(cur.base, pv.idx, cur.wide, 1'b0);
          nxt_core.rom.rd   = 1'b1;
          nxt_core.seq      = WTS_S_WAIT_HI;
        end
        else
        begin
          nxt_core.seq = WTS_S_NEXT;
        end
      end
      WTS_S_WAIT_HI:
      begin
        nxt_core.seq = WTS_S_GET_HI;
      end
      WTS_S_GET_HI:
      begin
        nxt_core.hi_byte = rom_data;
        nxt_core.lo_nib  = 4'h0;
        if (cur.wide && rom_data != `WTS_END_CODE)
        begin
          nxt_core.rom.addr = samp_addr(cur.base, pv.idx, 1'b1, 1'b1);
          nxt_core.rom.rd   = 1'b1;
          nxt_core.seq      = WTS_S_WAIT_LO;
        end
        else
        begin
          nxt_core.seq = WTS_S_MIX;
        end
      end
      WTS_S_WAIT_LO:
      begin
        nxt_core.seq = WTS_S_GET_LO;
      end
      WTS_S_GET_LO:
      begin
        // even sample holds the upper nibble, odd the lower
        nxt_core.lo_nib = pv.idx[0] ? rom_data[3:0] : rom_data[7:4];
        nxt_core.seq    = WTS_S_MIX;
      end
      WTS_S_MIX:
      begin
        if (core_ff.hi_byte == `WTS_END_CODE)
        begin
          // silent frame for this voice while it jumps back
          nxt_core.play[core_ff.voice].idx =
            pv.idx + {`WTS_LOOP_SEXT, cur.loop_off};
          nxt_core.play[core_ff.voice].frac   = 17'h00000;
          nxt_core.play[core_ff.voice].looped = 1'b1;
        end
        else
        begin
          nxt_core.acc = mix_sum;
          pos = pos + {6'h00, inc};
          nxt_core.play[core_ff.voice].idx  = pos[32:17];
          nxt_core.play[core_ff.voice].frac = pos[16:0];
        end
        nxt_core.cfg[core_ff.voice].atten = att_new;
        if (pv.looped && att_new[9:3] == `WTS_SILENT_HI)
        begin
          nxt_core.play[core_ff.voice].active = 1'b0;
        end
        nxt_core.seq = WTS_S_NEXT;
      end
      WTS_S_NEXT:
      begin
        if (core_ff.voice == `WTS_LAST_VOICE)
        begin
          nxt_core.last_done = 1'b1;
          nxt_core.seq       = WTS_S_IDLE;
        end
        else
        begin
          nxt_core.voice = core_ff.voice + 3'h1;
          nxt_core.seq   = WTS_S_REQ;
        end
      end
      default:
      begin
        nxt_core.seq = WTS_S_IDLE;
      end
    endcase

    // converter word: off, synthesizer mix, or the core's own word
    if (!core_ff.conv_en)
    begin
      nxt_core.conv_out = 16'h0000;
    end
    else if (core_ff.src_sel)
    begin
      if (core_ff.last_done)
      begin
        nxt_core.conv_out = core_ff.acc;
      end
    end
    else
    begin
      nxt_core.conv_out = {core_ff.conv_hi, core_ff.conv_lo};
    end

    // register writes; a write overrides the sweep in the same cycle
    if (reg_req.wr)
    begin
      if (reg_req.addr == `WTS_OFF_CONV_HI)
      begin
        nxt_core.conv_hi = reg_req.wdata;
      end
      else if (reg_req.addr == `WTS_OFF_CONV_LO)
      begin
        nxt_core.conv_lo = reg_req.wdata;
      end
      else if (reg_req.addr == `WTS_OFF_CONV_CTL)
      begin
        nxt_core.conv_en = reg_req.wdata[`WTS_BIT_CONV_EN];
        nxt_core.src_sel = reg_req.wdata[`WTS_BIT_SRC_SEL];
      end
      else if (reg_req.addr == `WTS_OFF_VOICE_SEL)
      begin
        nxt_core.vsel = {reg_req.wdata[7:6], 3'b000, v};
        case ({reg_req.wdata[`WTS_BIT_VOL_ONLY],
               reg_req.wdata[`WTS_BIT_PITCH_ONLY]})
          2'b00:
          begin
            // relies on the core having staged every field first
            nxt_core.cfg[v]         = core_ff.stage;
            nxt_core.play[v].active = 1'b1;
            nxt_core.play[v].looped = 1'b0;
            nxt_core.play[v].idx    = 16'h0000;
            nxt_core.play[v].frac   = 17'h00000;
          end
          2'b01:
          begin
            nxt_core.cfg[v].step  = core_ff.stage.step;
            nxt_core.cfg[v].shift = core_ff.stage.shift;
          end
          2'b10:
          begin
            nxt_core.cfg[v].atten = core_ff.stage.atten;
          end
          default:
          begin
            nxt_core.vsel = core_ff.vsel;
          end
        endcase
      end
      else if (reg_req.addr == `WTS_OFF_PITCH_HI)
      begin
        nxt_core.stage.shift      = reg_req.wdata[7:4];
        nxt_core.stage.step[11:8] = reg_req.wdata[3:0];
      end
      else if (reg_req.addr == `WTS_OFF_PITCH_LO)
      begin
        nxt_core.stage.step[7:0] = reg_req.wdata;
      end
      else if (reg_req.addr == `WTS_OFF_BASE_HI)
      begin
        nxt_core.stage.base[11:8] = reg_req.wdata[3:0];
      end
      else if (reg_req.addr == `WTS_OFF_BASE_LO)
      begin
        nxt_core.stage.base[7:0] = reg_req.wdata;
      end
      else if (reg_req.addr == `WTS_OFF_FMT_LOOP)
      begin
        nxt_core.stage.wide          = reg_req.wdata[`WTS_BIT_WIDE];
        nxt_core.stage.loop_off[9:8] = reg_req.wdata[1:0];
      end
      else if (reg_req.addr == `WTS_OFF_LOOP_LO)
      begin
        nxt_core.stage.loop_off[7:0] = reg_req.wdata;
      end
      else if (reg_req.addr == `WTS_OFF_ENV_VOL)
      begin
        nxt_core.stage.fade_dir   = reg_req.wdata[`WTS_BIT_FADE_DIR];
        nxt_core.stage.span       = reg_req.wdata[3:2];
        nxt_core.stage.atten[9:8] = reg_req.wdata[1:0];
      end
      else if (reg_req.addr == `WTS_OFF_VOL_LO)
      begin
        nxt_core.stage.atten[7:0] = reg_req.wdata;
      end
    end

    // power-off blanks the word in the same edge, so it never lags the enable going low
    if (!nxt_core.conv_en)
    begin
      nxt_core.conv_out = 16'h0000;
    end

    // reads answer one cycle later; holes and spare bits give zero
    nxt_core.rdata = 8'h00;
    if (reg_req.rd)
    begin
      if (reg_req.addr == `WTS_OFF_CONV_HI)
      begin
        nxt_core.rdata = core_ff.conv_hi;
      end
      else if (reg_req.addr == `WTS_OFF_CONV_LO)
      begin
        nxt_core.rdata = core_ff.conv_lo;
      end
      else if (reg_req.addr == `WTS_OFF_CONV_CTL)
      begin
        nxt_core.rdata = {6'h00, core_ff.conv_en, core_ff.src_sel};
      end
      else if (reg_req.addr == `WTS_OFF_VOICE_SEL)
      begin
        nxt_core.rdata = core_ff.vsel;
      end
      else if (reg_req.addr == `WTS_OFF_PITCH_HI)
      begin
        nxt_core.rdata = {core_ff.stage.shift, core_ff.stage.step[11:8]};
      end
      else if (reg_req.addr == `WTS_OFF_PITCH_LO)
      begin
        nxt_core.rdata = core_ff.stage.step[7:0];
      end
      else if (reg_req.addr == `WTS_OFF_BASE_HI)
      begin
        nxt_core.rdata = {4'h0, core_ff.stage.base[11:8]};
      end
      else if (reg_req.addr == `WTS_OFF_BASE_LO)
      begin
        nxt_core.rdata = core_ff.stage.base[7:0];
      end
      else if (reg_req.addr == `WTS_OFF_FMT_LOOP)
      begin
        nxt_core.rdata = {core_ff.stage.wide, 5'h00,
                          core_ff.stage.loop_off[9:8]};
      end
      else if (reg_req.addr == `WTS_OFF_LOOP_LO)
      begin
        nxt_core.rdata = core_ff.stage.loop_off[7:0];
      end
      else if (reg_req.addr == `WTS_OFF_ENV_VOL)
      begin
        nxt_core.rdata = {core_ff.stage.fade_dir, 3'h0, core_ff.stage.span,
                          core_ff.stage.atten[9:8]};
      end
      else if (reg_req.addr == `WTS_OFF_VOL_LO)
      begin
        nxt_core.rdata = core_ff.stage.atten[7:0];
      end
    end

    // word and parameter bytes keep whatever they held
    if (rst)
    begin
      nxt_core.conv_en   = `WTS_RST_CTL;
      nxt_core.src_sel   = `WTS_RST_CTL;
      nxt_core.vsel      = `WTS_RST_VSEL;
      nxt_core.seq       = WTS_S_IDLE;
      nxt_core.cyc       = 12'h000;
      nxt_core.voice     = 3'h0;
      nxt_core.last_done = 1'b0;
      nxt_core.acc       = 16'h0000;
      nxt_core.rom       = '0;
      nxt_core.rdata     = 8'h00;
      nxt_core.conv_out  = 16'h0000;
      for (int i = 0; i < 8; i++)
      begin
        nxt_core.play[i].active = 1'b0;
        nxt_core.play[i].looped = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    core_ff <= nxt_core;
  end

  assign reg_rdata = core_ff.rdata;
  assign rom_req   = core_ff.rom;
  assign conv_on   = core_ff.conv_en;
  assign conv_word = core_ff.conv_out;

endmodule : wts_top

// file: bench/wts_checker.sv
/*
  Port checks of the wavetable engine, bound to its top module.
  Assumes the map header and the package are compiled first.
*/
`timescale 1ns/1ps
`include "wts_map.svh"
module wts_checker
(
  input wire logic                  core_clk,
  input wire logic                  rst,
  input wire wts_pkg::wts_reg_req_t reg_req,
  input wire logic [7:0]            reg_rdata,
  input wire wts_pkg::wts_rom_req_t rom_req,
  input wire logic [7:0]            rom_data,
  input wire logic                  conv_on,
  input wire logic [15:0]           conv_word
);
  import wts_pkg::*;
  localparam int FRAME = `WTS_FRAME_CYC;
  logic        src_ff;
  logic [15:0] word_ff;
  logic [11:0] fcnt_ff;
  // word shadow is not reset: the engine keeps its bytes over reset too
  always_ff @(posedge core_clk)
  begin
    if (reg_req.wr && reg_req.addr == `WTS_OFF_CONV_HI)
      word_ff[15:8] <= reg_req.wdata;
    if (reg_req.wr && reg_req.addr == `WTS_OFF_CONV_LO)
      word_ff[7:0] <= reg_req.wdata;
    if (rst)
      src_ff <= 1'b0;
    else if (reg_req.wr && reg_req.addr == `WTS_OFF_CONV_CTL)
      src_ff <= reg_req.wdata[0];
    if (rst || fcnt_ff == 12'(FRAME - 1))
      fcnt_ff <= 12'h000;
    else
      fcnt_ff <= fcnt_ff + 12'h001;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  a_off_word_zero: assert property (!conv_on |-> conv_word == 16'h0000)
    else $error("converter word not zero while off");
  a_enable_write:
    assert property (reg_req.wr && reg_req.addr == `WTS_OFF_CONV_CTL
      |=> conv_on == $past(reg_req.wdata[1]))
    else $error("converter power does not follow control write");
  a_ctl_read:
    assert property (reg_req.rd && !reg_req.wr &&
      reg_req.addr == `WTS_OFF_CONV_CTL
      |=> reg_rdata == {6'h00, conv_on, src_ff})
    else $error("control readback wrong");
  a_core_word:
    assert property (conv_on && $past(conv_on) && !src_ff && !$past(src_ff)
      |-> conv_word == $past(word_ff))
    else $error("converter word does not follow core bytes");
  a_unused_zero:
    assert property (reg_req.rd && (reg_req.addr inside {8'h28, 8'h29,
      [8'h2B:8'h2F]}) |=> reg_rdata == 8'h00)
    else $error("unused location reads nonzero");
  a_vsel_spare:
    assert property (reg_req.rd && reg_req.addr == `WTS_OFF_VOICE_SEL
      |=> reg_rdata[5:3] == 3'h0)
    else $error("voice select spare bits nonzero");
  a_rom_pulse: assert property (rom_req.rd |=> !rom_req.rd)
    else $error("wave read strobe longer than one cycle");
  a_rom_hold: assert property (!rom_req.rd |-> $stable(rom_req.addr))
    else $error("wave address moved without a read");
  a_frame_slot: assert property (rom_req.rd |-> fcnt_ff < 12'd200)
    else $error("wave read outside frame service window");
  c_rom_read: cover property (rom_req.rd);
  c_voice_start: cover property (reg_req.wr && reg_req.addr == 8'h20);
  c_synth_out: cover property (conv_on && src_ff && conv_word != 16'h0000);
endmodule : wts_checker

bind wts_top wts_checker u_chk
(
  .core_clk  (core_clk),
  .rst       (rst),
  .reg_req   (reg_req),
  .reg_rdata (reg_rdata),
  .rom_req   (rom_req),
  .rom_data  (rom_data),
  .conv_on   (conv_on),
  .conv_word (conv_word)
);

// file: bench/wts_rom_model.sv
/*
  Behavioural wave ROM that answers one cycle after a read strobe.
  Assumes the bench loads mem before any voice starts.
*/
`timescale 1ns/1ps
module wts_rom_model
(
  input  wire logic                  core_clk,
  input  wire wts_pkg::wts_rom_req_t rom_req,
  output logic [7:0]                 rom_data
);
  import wts_pkg::*;
  logic [7:0] mem [0:127];
  logic [7:0] data_q = 8'hA5;
  // outside the answer cycle the byte flips, so a late sample is caught
  always @(posedge core_clk)
  begin
    if (rom_req.rd)
      data_q <= mem[rom_req.addr[6:0]];
    else
      data_q <= ~data_q;
  end
  assign rom_data = data_q;
endmodule : wts_rom_model

// file: bench/tb.sv
/*
  Self-checking bench: register port, wave reads and converter word
  are compared against queued expectations.
  Assumes design, checker and ROM model are compiled before it.
*/
`timescale 1ns/1ps
`include "wts_map.svh"
module tb;
  import wts_pkg::*;
  logic         core_clk = 1'b0;
  logic         rst = 1'b1;
  wts_reg_req_t reg_req = '0;
  logic [7:0]   reg_rdata;
  wts_rom_req_t rom_req;
  logic [7:0]   rom_data;
  logic         conv_on;
  logic [15:0]  conv_word;
  logic         rd_pend = 1'b0;
  logic         look = 1'b0;
  int           n_errors = 0;
  int           n_tests = 0;
  int           cyc = 0;
  logic [15:0]  rq[$];
  logic [15:0]  aq[$];
  logic [15:0]  cq[$];
  logic [15:0]  w;

  always #5 core_clk = ~core_clk;

  wts_top dut
  (
    .core_clk  (core_clk),
    .rst       (rst),
    .reg_req   (reg_req),
    .reg_rdata (reg_rdata),
    .rom_req   (rom_req),
    .rom_data  (rom_data),
    .conv_on   (conv_on),
    .conv_word (conv_word)
  );
  wts_rom_model rom
  (
    .core_clk (core_clk),
    .rom_req  (rom_req),
    .rom_data (rom_data)
  );

  task automatic summarize;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_req.wr    <= 1'b1;
    reg_req.addr  <= a;
    reg_req.wdata <= d;
    @(posedge core_clk);
    reg_req.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    rq.push_back({8'h00, e});
    @(posedge core_clk);
    reg_req.rd   <= 1'b1;
    reg_req.addr <= a;
    @(posedge core_clk);
    reg_req.rd <= 1'b0;
  endtask : rd

  task automatic see_conv(input logic [15:0] e);
    cq.push_back(e);
    @(posedge core_clk);
    look <= 1'b1;
    @(posedge core_clk);
    look <= 1'b0;
  endtask : see_conv

  // step 800H with shift 6 moves one sample a frame; loop back two
  task automatic voice(input logic [7:0] base, input logic [7:0] fmt,
                       input logic [7:0] sel);
    wr(`WTS_OFF_PITCH_HI, 8'h68);
    wr(`WTS_OFF_PITCH_LO, 8'h00);
    wr(`WTS_OFF_BASE_HI, 8'h00);
    wr(`WTS_OFF_BASE_LO, base);
    wr(`WTS_OFF_FMT_LOOP, fmt);
    wr(`WTS_OFF_LOOP_LO, 8'hFE);
    wr(`WTS_OFF_ENV_VOL, 8'h0C);
    wr(`WTS_OFF_VOL_LO, 8'h00);
    wr(`WTS_OFF_VOICE_SEL, sel);
  endtask : voice

  // a missing wave read counts as one mismatch
  task automatic drain;
    int k;
    k = 0;
    while (aq.size() > 0 && k < 28000)
    begin
      @(posedge core_clk);
      k++;
    end
    if (aq.size() > 0)
    begin
      n_errors++;
      aq.delete();
    end
  endtask : drain

  always @(posedge core_clk)
  begin
    rd_pend <= reg_req.rd;
    cyc++;
    if (cyc == 100000)
    begin
      n_errors++;
      summarize();
    end
  end

  always @(negedge core_clk)
  begin
    if (rd_pend)
      check({8'h00, reg_rdata}, rq.pop_front());
    if (look)
      check(conv_word, cq.pop_front());
    if (rom_req.rd && aq.size() > 0)
      check(rom_req.addr, aq.pop_front());
  end

  initial
  begin
    for (int i = 0; i < 128; i++)
      rom.mem[i] = 8'h00;
    for (int i = 0; i < 4; i++)
      rom.mem[8'h20 + i] = 8'h40;
    rom.mem[8'h24] = `WTS_END_CODE;
    for (int i = 0; i < 6; i++)
      rom.mem[8'h40 + i] = 8'(8'h12 + 8'h22 * i);
    rom.mem[8'h46] = `WTS_END_CODE;
    w = 16'($urandom(32'hA3C5));
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    rd(`WTS_OFF_CONV_CTL, 8'h00);
    rd(`WTS_OFF_VOICE_SEL, 8'h00);
    see_conv(16'h0000);
    for (int a = 8'h28; a <= 8'h2F; a++)
      if (a != 8'h2A)
      begin
        wr(8'(a), 8'($urandom));
        rd(8'(a), 8'h00);
      end
    repeat (3)
    begin
      w = 16'($urandom);
      wr(`WTS_OFF_CONV_HI, w[15:8]);
      wr(`WTS_OFF_CONV_LO, w[7:0]);
      wr(`WTS_OFF_CONV_CTL, 8'hFE);
      see_conv(w);
      rd(`WTS_OFF_CONV_HI, w[15:8]);
      rd(`WTS_OFF_CONV_LO, w[7:0]);
    end
    rd(`WTS_OFF_CONV_CTL, 8'h02);
    wr(`WTS_OFF_CONV_CTL, 8'h01);
    see_conv(16'h0000);
    rd(`WTS_OFF_CONV_CTL, 8'h01);
    wr(`WTS_OFF_CONV_CTL, 8'h03);
    aq = {16'h0020, 16'h0021, 16'h0022, 16'h0023, 16'h0024, 16'h0022};
    voice(8'h01, 8'h03, 8'h00);
    drain();
    // sample 400H at full gain gives 3FF0H once the sweep has ended
    repeat (40) @(posedge core_clk);
    see_conv(16'h3FF0);
    aq = {16'h0023, 16'h0024, 16'h0022};
    voice(8'h03, 8'h03, 8'h40);
    drain();
    rd(`WTS_OFF_VOICE_SEL, 8'h40);
    wr(`WTS_OFF_VOICE_SEL, 8'hC0);
    rd(`WTS_OFF_VOICE_SEL, 8'h40);
    aq = {16'h0023, 16'h0024};
    wr(`WTS_OFF_VOICE_SEL, 8'h80);
    drain();
    aq = {16'h0040, 16'h0042, 16'h0041, 16'h0042, 16'h0043, 16'h0045,
          16'h0044, 16'h0045, 16'h0046, 16'h0043, 16'h0045};
    voice(8'h02, 8'h83, 8'h00);
    drain();
    // packed sample 78BH at full gain gives 7891H
    repeat (40) @(posedge core_clk);
    see_conv(16'h7891);
    rd(`WTS_OFF_PITCH_HI, 8'h68);
    rd(`WTS_OFF_FMT_LOOP, 8'h83);
    rd(`WTS_OFF_ENV_VOL, 8'h0C);
    summarize();
  end
endmodule : tb
